// ==== core/buffer_status_upper.sv ====
`timescale 1ns/1ns
module buffer_status_upper
  import buf_status_pkg::*;
(
  input  wire logic                            clk_sys,
  input  wire logic                            srst,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [ADDR_W-1:0]               paddr,
  input  wire logic [31:0]                     pwdata,
  output logic                                 pready,
  output logic [31:0]                          prdata,
  output logic                                 pslverr,
  input  wire logic [NUM_BUF-1:0][LEVEL_W-1:0] levelIn,
  input  wire logic [NUM_BUF-1:0]              cellConfirm,
  input  wire logic [NUM_BUF-1:0]              cellTaken,
  output logic [31:0]                          statusWord,
  output logic                                 irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////////////////////

  // Per buffer first and second thresholds.
  logic [NUM_BUF-1:0][LEVEL_W-1:0]    threshA_r;
  logic [NUM_BUF-1:0][LEVEL_W-1:0]    threshB_r;

  // Direction controls, one lane per buffer.
  logic [31:0]                        dir_r;

  // Sticky event bits and their mask, same layout as the status word.
  logic [31:0]                        intStat_r;
  logic [31:0]                        intStat_nxt;
  logic [31:0]                        intMask_r;

  // Status word of the last cycle, used to find rising flags.
  logic [31:0]                        statusPrev_r;

  // Confirmed cells not yet taken, per buffer.
  logic [NUM_BUF-1:0][CELL_CNT_W-1:0] cellCnt_r;

  // Flags from the per buffer evaluators.
  logic [NUM_BUF-1:0]                 noData;
  logic [NUM_BUF-1:0]                 noSpace;
  logic [NUM_BUF-1:0]                 markA;
  logic [NUM_BUF-1:0]                 markB;

  // Events that raise sticky bits this cycle.
  logic [31:0]                        events;

  // Read mux and decode results.
  logic [31:0]                        rdData;
  logic                               addrHit;
  logic                               wrCommit;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  ////////////////////////////////////////////////////////////////////////////

  // Threshold words sit at four consecutive word addresses.
  function automatic logic isThresh(input logic [ADDR_W-1:0] a);
    isThresh = (a[ADDR_W-1:4] == THRESH_OFF[ADDR_W-1:4]) && (a[1:0] == 2'h0);
  endfunction

  // Index of the threshold word that an address selects.
  function automatic logic [1:0] threshIdx(input logic [ADDR_W-1:0] a);
    threshIdx = a[3:2];
  endfunction

  // Every mapped word, the status word among them.
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a == STATUS_OFF) || (a == INT_STAT_OFF) || (a == INT_MASK_OFF)
             || (a == DIR_OFF) || isThresh(a);
  endfunction

  assign addrHit = isMapped(paddr);

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake
  ////////////////////////////////////////////////////////////////////////////

  // The port answers one cycle into the access phase.
  apb_reg_port u_port (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .rdData   (rdData),
    .addrHit  (addrHit),
    .pready   (pready),
    .prdata   (prdata),
    .pslverr  (pslverr),
    .wrCommit (wrCommit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per buffer flags
  ////////////////////////////////////////////////////////////////////////////

  genvar g;
  generate
    for (g = 0; g < NUM_BUF; g++)
    begin : g_buf
      // Level flags are evaluated from the live quadlet count.
      level_mark_eval u_eval (
        .clk_sys (clk_sys),
        .srst    (srst),
        .level   (levelIn[g]),
        .threshA (threshA_r[g]),
        .threshB (threshB_r[g]),
        .dirA    (dir_r[LANE_W*g+DIR_A_POS]),
        .dirB    (dir_r[LANE_W*g+DIR_B_POS]),
        .noData  (noData[g]),
        .noSpace (noSpace[g]),
        .markA   (markA[g]),
        .markB   (markB[g])
      );

      // Lane of the status word; upper three bits stay zero.
      // reserved bits zero
      assign statusWord[LANE_W*g +: LANE_W] = {3'b000,
                                               markB[g],
                                               markA[g],
                                               (cellCnt_r[g] != '0),
                                               noSpace[g],
                                               noData[g]};

      // Cell confirm is taken as an event itself, so that back to back
      // cells each raise the sticky bit even while the flag stays high.
      assign events[LANE_W*g +: LANE_W] = {3'b000,
                                           statusWord[LANE_W*g+MARK_B_POS] & ~statusPrev_r[LANE_W*g+MARK_B_POS],
                                           statusWord[LANE_W*g+MARK_A_POS] & ~statusPrev_r[LANE_W*g+MARK_A_POS],
                                           cellConfirm[g],
                                           statusWord[LANE_W*g+NO_SPACE_POS] & ~statusPrev_r[LANE_W*g+NO_SPACE_POS],
                                           statusWord[LANE_W*g+NO_DATA_POS] & ~statusPrev_r[LANE_W*g+NO_DATA_POS]};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Cell accounting
  ////////////////////////////////////////////////////////////////////////////

  // The count saturates at both ends; a take with no cell held is dropped,
  // which covers a consumer that ignores the cell flag.
  // cell available count
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      cellCnt_r <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_BUF; i++)
      begin
        if (cellConfirm[i] && !cellTaken[i] && cellCnt_r[i] != '1)
        begin
          cellCnt_r[i] <= cellCnt_r[i] + 4'h1;
        end
        else if (cellTaken[i] && !cellConfirm[i] && cellCnt_r[i] != '0)
        begin
          cellCnt_r[i] <= cellCnt_r[i] - 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  ////////////////////////////////////////////////////////////////////////////

  // Thresholds are written one word per buffer.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      for (int i = 0; i < NUM_BUF; i++)
      begin
        threshA_r[i] <= THRESH_A_RST;
        threshB_r[i] <= THRESH_B_RST;
      end
    end
    else if (wrCommit && isThresh(paddr))
    begin
      threshA_r[threshIdx(paddr)] <= pwdata[THRESH_A_LSB +: LEVEL_W];
      threshB_r[threshIdx(paddr)] <= pwdata[THRESH_B_LSB +: LEVEL_W];
    end
  end

  // Direction bits; only the two used bits of each lane are kept.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      dir_r <= '0;
      for (int i = 0; i < NUM_BUF; i++)
      begin
        dir_r[LANE_W*i+DIR_A_POS] <= DIR_A_RST;
        dir_r[LANE_W*i+DIR_B_POS] <= DIR_B_RST;
      end
    end
    else if (wrCommit && paddr == DIR_OFF)
    begin
      dir_r <= pwdata & {NUM_BUF{8'h03}};
    end
  end

  // Mask register, same layout as the status word.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      intMask_r <= '0;
    end
    else if (wrCommit && paddr == INT_MASK_OFF)
    begin
      intMask_r <= pwdata & {NUM_BUF{LANE_USED}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts
  ////////////////////////////////////////////////////////////////////////////

  // A new event wins over a write-one clear in the same cycle, so no
  // event is lost while software services the previous one.
  always_comb
  begin
    intStat_nxt = intStat_r;
    if (wrCommit && paddr == INT_STAT_OFF)
    begin
      intStat_nxt = intStat_nxt & ~pwdata;
    end
    intStat_nxt = (intStat_nxt | events) & {NUM_BUF{LANE_USED}};
  end

  // Sticky event bits.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      intStat_r <= '0;
    end
    else
    begin
      intStat_r <= intStat_nxt;
    end
  end

  // Previous status; reset to the flag reset pattern so the release
  // of reset itself raises no event.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      statusPrev_r <= '0;
      for (int i = 0; i < NUM_BUF; i++)
      begin
        statusPrev_r[LANE_W*i+NO_DATA_POS] <= NO_DATA_RST;
        statusPrev_r[LANE_W*i+MARK_A_POS]  <= MARK_A_RST;
      end
    end
    else
    begin
      statusPrev_r <= statusWord;
    end
  end

  // Level interrupt while any unmasked sticky bit is set.
  assign irq = |(intStat_r & intMask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  ////////////////////////////////////////////////////////////////////////////

  // Writes to the status word fall through every write decoder above,
  // so its flags stay under hardware control alone.
  // status word read only
  always_comb
  begin
    rdData = 32'h0000_0000;
    if (paddr == STATUS_OFF)
    begin
      rdData = statusWord;
    end
    else if (paddr == INT_STAT_OFF)
    begin
      rdData = intStat_r;
    end
    else if (paddr == INT_MASK_OFF)
    begin
      rdData = intMask_r;
    end
    else if (paddr == DIR_OFF)
    begin
      rdData = dir_r;
    end
    else if (isThresh(paddr))
    begin
      rdData[THRESH_A_LSB +: LEVEL_W] = threshA_r[threshIdx(paddr)];
      rdData[THRESH_B_LSB +: LEVEL_W] = threshB_r[threshIdx(paddr)];
    end
  end

  // Reads of an empty buffer and writes to a full one are the datapath's
  // concern; this block only publishes the flags that software must obey.
  // empty flag published

endmodule

// ==== core/buf_status_pkg.sv ====
package buf_status_pkg;

  // Buffers 4 to 7 are handled, one byte lane each.
  localparam int NUM_BUF    = 4;
  localparam int LANE_W     = 8;
  localparam int LEVEL_W    = 12;
  localparam int CELL_CNT_W = 4;
  localparam int ADDR_W     = 12;

  // Capacity of one buffer in quadlets.
  localparam logic [LEVEL_W-1:0] BUF_DEPTH = 12'h800;

  // Byte addresses of the registers.
  localparam logic [ADDR_W-1:0] STATUS_OFF   = 12'h148;
  localparam logic [ADDR_W-1:0] INT_STAT_OFF = 12'h180;
  localparam logic [ADDR_W-1:0] INT_MASK_OFF = 12'h184;
  localparam logic [ADDR_W-1:0] DIR_OFF      = 12'h188;
  localparam logic [ADDR_W-1:0] THRESH_OFF   = 12'h190;

  // Field positions inside one lane of the status word.
  localparam int NO_DATA_POS  = 0;
  localparam int NO_SPACE_POS = 1;
  localparam int CELL_POS     = 2;
  localparam int MARK_A_POS   = 3;
  localparam int MARK_B_POS   = 4;

  // Field positions of the direction lane and threshold word.
  localparam int DIR_A_POS    = 0;
  localparam int DIR_B_POS    = 1;
  localparam int THRESH_A_LSB = 0;
  localparam int THRESH_B_LSB = 16;

  // Reset values of the flags.
  localparam logic NO_DATA_RST  = 1'b1;
  localparam logic NO_SPACE_RST = 1'b0;
  localparam logic CELL_RST     = 1'b0;
  localparam logic MARK_A_RST   = 1'b1;
  localparam logic MARK_B_RST   = 1'b0;

  // Reset values of the control registers; they agree with the flag resets.
  localparam logic [LEVEL_W-1:0] THRESH_A_RST = 12'h001;
  localparam logic [LEVEL_W-1:0] THRESH_B_RST = 12'h000;
  localparam logic               DIR_A_RST    = 1'b0;
  localparam logic               DIR_B_RST    = 1'b1;

  // Bits of a lane that carry state; the rest are reserved.
  localparam logic [LANE_W-1:0] LANE_USED = 8'h1f;

  // Bus answer state.
  typedef enum logic [0:0] {
    APB_IDLE   = 1'b0,
    APB_ANSWER = 1'b1
  } apb_state_t;

endpackage

// ==== core/level_mark_eval.sv ====
`timescale 1ns/1ns
module level_mark_eval
  import buf_status_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               srst,
  input  wire logic [LEVEL_W-1:0] level,
  input  wire logic [LEVEL_W-1:0] threshA,
  input  wire logic [LEVEL_W-1:0] threshB,
  input  wire logic               dirA,
  input  wire logic               dirB,
  output logic                    noData,
  output logic                    noSpace,
  output logic                    markA,
  output logic                    markB
);

  // A one in the direction bit asks for a rise above the threshold,
  // a zero for a fall below it.
  function automatic logic crossed(input logic [LEVEL_W-1:0] lvl,
                                   input logic [LEVEL_W-1:0] thr,
                                   input logic               up);
    crossed = up ? (lvl > thr) : (lvl < thr);
  endfunction

  // Flags are refreshed every cycle so that they track the level
  // without any software action.
  // continuous hardware update
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      noData  <= NO_DATA_RST;
      noSpace <= NO_SPACE_RST;
      markA   <= MARK_A_RST;
      markB   <= MARK_B_RST;
    end
    else
    begin
      noData  <= (level == '0);
      noSpace <= (level >= BUF_DEPTH);
      markA   <= crossed(level, threshA, dirA);
      markB   <= crossed(level, threshB, dirB);
    end
  end

endmodule

// ==== core/apb_reg_port.sv ====
`timescale 1ns/1ns
module apb_reg_port
  import buf_status_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] rdData,
  input  wire logic        addrHit,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             wrCommit
);

  apb_state_t state_r;  // Answer state.

  // One wait cycle lets read data and error come from flip-flops.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_r <= APB_IDLE;
    end
    else
    begin
      case (state_r)
        APB_IDLE:
        begin
          if (psel && penable)
          begin
            state_r <= APB_ANSWER;
          end
        end
        APB_ANSWER:
        begin
          state_r <= APB_IDLE;
        end
        default:
        begin
          state_r <= APB_IDLE;
        end
      endcase
    end
  end

  // Read data and error are captured in the first access cycle.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (state_r == APB_IDLE && psel && penable)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : rdData;
      pslverr <= !addrHit;
    end
    else if (state_r == APB_ANSWER)
    begin
      pslverr <= 1'b0;
    end
  end

  // Ready is high in the second access cycle only.
  assign pready = (state_r == APB_ANSWER);

  // A write lands at the edge where the master samples ready.
  assign wrCommit = (state_r == APB_ANSWER) && psel && penable && pwrite && addrHit;

endmodule

// ==== dv/buffer_status_upper_monitor.sv ====
`timescale 1ns/1ns
module buffer_status_upper_monitor
  import buf_status_pkg::*;
(
  input wire logic                            clk_sys,
  input wire logic                            srst,
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic                            pwrite,
  input wire logic [ADDR_W-1:0]               paddr,
  input wire logic                            pready,
  input wire logic [31:0]                     prdata,
  input wire logic                            pslverr,
  input wire logic [NUM_BUF-1:0][LEVEL_W-1:0] levelIn,
  input wire logic [NUM_BUF-1:0]              cellConfirm,
  input wire logic [NUM_BUF-1:0]              cellTaken,
  input wire logic [31:0]                     statusWord
);

  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  // Flags are registered, so each is held against the level one cycle back.
  // The first edge after reset is skipped because the flops still load then.
  a_empty_lane4: assert property (!$past(srst) |-> statusWord[0] == ($past(levelIn[0]) == 12'h000))
    else $error("empty flag of buffer 4 wrong");
  a_full_lane6: assert property (!$past(srst) |-> statusWord[17] == ($past(levelIn[2]) >= BUF_DEPTH))
    else $error("full flag of buffer 6 wrong");
  a_full_lane7: assert property (!$past(srst) |-> statusWord[25] == ($past(levelIn[3]) >= BUF_DEPTH))
    else $error("full flag of buffer 7 wrong");
  a_reserved_zero: assert property ((statusWord & 32'he0e0e0e0) == 32'h0)
    else $error("reserved status bits not zero");

  ////////////////////////////////////////////////////////////////////////////
  // A confirmed cell shows one cycle later and only a confirm can raise the flag.
  a_cell_set: assert property (cellConfirm[1] && !cellTaken[1] |=> statusWord[10])
    else $error("cell flag of buffer 5 not set");
  a_cell_cause: assert property ($rose(statusWord[18]) |-> $past(cellConfirm[2]))
    else $error("cell flag of buffer 6 rose without confirm");

  ////////////////////////////////////////////////////////////////////////////
  // The bus answer carries the live word; one wait state is promised.
  a_ready_wait: assert property (psel && !penable |-> ##2 pready)
    else $error("bus answer not two cycles after setup");
  a_read_status: assert property (pready && !pwrite && paddr == STATUS_OFF |-> !pslverr && prdata == $past(statusWord))
    else $error("status read data differs from live word");

endmodule

// ==== dv/tb_data_buffer_status_upper.sv ====
`timescale 1ns/1ns
module tb_data_buffer_status_upper
  import buf_status_pkg::*;
;
  logic                            clk_sys;      // System clock.
  logic                            srst;         // Synchronous reset.
  logic                            psel;         // Bus select.
  logic                            penable;      // Bus enable.
  logic                            pwrite;       // Bus direction.
  logic [ADDR_W-1:0]               paddr;        // Bus address.
  logic [31:0]                     pwdata;       // Bus write data.
  logic                            pready;       // Bus ready.
  logic [31:0]                     prdata;       // Bus read data.
  logic                            pslverr;      // Bus error.
  logic [NUM_BUF-1:0][LEVEL_W-1:0] levelIn;      // Quadlet counts.
  logic [NUM_BUF-1:0]              cellConfirm;  // Cell confirm pulses.
  logic [NUM_BUF-1:0]              cellTaken;    // Cell consume pulses.
  logic [31:0]                     statusWord;   // Live status word.
  logic                            irq;          // Interrupt line.
  logic [LEVEL_W-1:0]              lvl [NUM_BUF];  // Expected-side copy of levels.
  logic [LEVEL_W-1:0]              thrA [NUM_BUF]; // Expected first thresholds.
  logic [LEVEL_W-1:0]              thrB [NUM_BUF]; // Expected second thresholds.
  logic                            dirA [NUM_BUF]; // Expected first directions.
  logic                            dirB [NUM_BUF]; // Expected second directions.
  int                              cells [NUM_BUF]; // Expected cells held.
  int                              failures;     // Mismatches seen.
  int                              check_count;  // Comparisons made.
  logic [31:0]                     rd;           // Last read data.
  logic                            er;           // Last error bit.

  buffer_status_upper uut (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .levelIn(levelIn),
    .cellConfirm(cellConfirm), .cellTaken(cellTaken), .statusWord(statusWord), .irq(irq));

  // Free-running 100 MHz clock.
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////
  // Builds the word the flags should show from the levels and settings.
  function automatic logic [31:0] exp_word();
    logic [31:0] w;
    w = 32'h0;
    for (int i = 0; i < NUM_BUF; i++)
    begin
      w[8*i]   = (lvl[i] == 12'h000);
      w[8*i+1] = (lvl[i] >= BUF_DEPTH);
      w[8*i+2] = (cells[i] != 0);
      w[8*i+3] = dirA[i] ? (lvl[i] > thrA[i]) : (lvl[i] < thrA[i]);
      w[8*i+4] = dirB[i] ? (lvl[i] > thrB[i]) : (lvl[i] < thrB[i]);
    end
    return w;
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task stop_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Compares one value with its expectation.
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus transfer; the request stands until pready is seen high.
  task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      failures++;
      stop_test();
    end
  endtask

  // Applies new levels and lets the flags settle.
  task apply(input logic [NUM_BUF-1:0][LEVEL_W-1:0] v);
    @(posedge clk_sys);
    levelIn <= v;
    for (int i = 0; i < NUM_BUF; i++)
      lvl[i] = v[i];
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  // Pulses the cell inputs; a confirm and a take together cancel.
  task pulse(input logic [NUM_BUF-1:0] conf, input logic [NUM_BUF-1:0] take);
    @(posedge clk_sys);
    cellConfirm <= conf;
    cellTaken <= take;
    @(posedge clk_sys);
    cellConfirm <= '0;
    cellTaken <= '0;
    for (int i = 0; i < NUM_BUF; i++)
      if (conf[i] && !take[i] && cells[i] < 15)
        cells[i]++;
      else if (take[i] && !conf[i] && cells[i] > 0)
        cells[i]--;
    #1;
  endtask

  // Checks the live word and the same word read over the bus.
  task verify();
    check(statusWord, exp_word());
    apb(1'b0, STATUS_OFF, 32'h0);
    check(rd, exp_word());
    check({31'h0, er}, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {srst, psel, penable, pwrite, paddr, pwdata, levelIn, cellConfirm, cellTaken} = '0;
    srst = 1'b1;
    failures = 0;
    check_count = 0;
    for (int i = 0; i < NUM_BUF; i++)
    begin
      {lvl[i], thrA[i], thrB[i], dirA[i], dirB[i], cells[i]} = {12'h000, 12'h001, 12'h000, 1'b0, 1'b1, 32'h0};
    end
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    check(statusWord, 32'h09090909);
    check({31'h0, irq}, 32'h0);
    verify();
    $display("test reset values done");
    // Boundary levels around full in every lane, around empty in all but buffer 6; no level passes capacity.
    apply({12'h800, 12'h7ff, 12'h001, 12'h000});
    verify();
    apply({12'h000, 12'h800, 12'h7ff, 12'h800});
    verify();
    $display("test empty and full done");
    // Reverse both directions and move thresholds, then cross them.
    apb(1'b1, DIR_OFF, 32'h01010101);
    for (int k = 0; k < NUM_BUF; k++)
    begin
      apb(1'b1, THRESH_OFF + ADDR_W'(4 * k), 32'h02000100);
      {thrA[k], thrB[k], dirA[k], dirB[k]} = {12'h100, 12'h200, 1'b1, 1'b0};
    end
    apply({12'h200, 12'h1ff, 12'h101, 12'h100});
    verify();
    apply({12'h0ff, 12'h100, 12'h201, 12'h1ff});
    verify();
    $display("test level marks done");
    // Software writes to the status word are ignored; a read of an unmapped word gets an error and zero data.
    apb(1'b1, STATUS_OFF, 32'hffffffff);
    check({31'h0, er}, 32'h0);
    verify();
    apb(1'b0, 12'h144, 32'h0);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    $display("test writes ignored done");
    // Cells arrive, cancel and are consumed; a take only ever meets a held cell.
    pulse(4'hf, 4'h0);
    verify();
    pulse(4'h5, 4'h5);
    verify();
    pulse(4'h0, 4'hf);
    verify();
    $display("test cell flags done");
    // A masked-out event stays quiet, a masked-in one raises the line.
    apb(1'b1, INT_STAT_OFF, 32'hffffffff);
    apb(1'b1, INT_MASK_OFF, 32'h00000004);
    pulse(4'h2, 4'h0);
    @(posedge clk_sys);
    #1;
    check({31'h0, irq}, 32'h0);
    pulse(4'h1, 4'h0);
    @(posedge clk_sys);
    #1;
    check({31'h0, irq}, 32'h1);
    apb(1'b0, INT_STAT_OFF, 32'h0);
    check(rd, 32'h00000404);
    apb(1'b1, INT_STAT_OFF, 32'h00000004);
    repeat (2) @(posedge clk_sys);
    #1;
    check({31'h0, irq}, 32'h0);
    verify();
    $display("test interrupt done");
    // A reset in mid-run brings flags, counters and registers back.
    pulse(4'h1, 4'h0);
    check({31'h0, irq}, 32'h1);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    for (int i = 0; i < NUM_BUF; i++)
    begin
      {thrA[i], thrB[i], dirA[i], dirB[i], cells[i]} = {12'h001, 12'h000, 1'b0, 1'b1, 32'h0};
    end
    #1;
    check(statusWord, 32'h09090909);
    check({31'h0, irq}, 32'h0);
    @(posedge clk_sys);
    #1;
    verify();
    $display("test mid-run reset done");
    stop_test();
  end

endmodule

bind buffer_status_upper buffer_status_upper_monitor mon (.clk_sys(clk_sys), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .levelIn(levelIn), .cellConfirm(cellConfirm), .cellTaken(cellTaken), .statusWord(statusWord));
